/* File: ecs_pkg.sv */
// Shared constants, types and states of the eight-channel BCD converter scanner
package ecs_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SCAN_TIME_MS = 320;
  localparam int unsigned SCAN_CYCLES = SCAN_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned CONV_CLK_HZ = 400_000;

  localparam int CHAN_W = 3;
  localparam int NUM_CHAN = 8;
  localparam logic [CHAN_W-1:0] LAST_CHAN = 3'h7;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] STORE_BASE = 16'h0010;
  localparam logic [ADDR_W-1:0] CHAN_STRIDE = 16'h0004;

  localparam logic [1:0] CYCLES_FIRST_AFTER_SYNC = 2'h2;
  localparam logic [1:0] CYCLES_LATER = 2'h2;

  localparam logic [7:0] PTR_START = 8'h10;
  localparam logic [7:0] PTR_LAST = 8'h80;
  localparam logic [3:0] BCD_MASK = 4'hf;

  localparam logic [3:0] RANGE_MASK = 4'hb;
  localparam logic [3:0] OVER_CODE = 4'h3;
  localparam logic [7:0] OVER_MARK = 8'hf1;
  localparam int HALF_BIT = 3;
  localparam int POL_BIT = 2;

  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ecs_mem_write_s;

  localparam int WR_W = ADDR_W + DATA_W;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SYNC,
    ST_WAIT,
    ST_COLLECT,
    ST_FIX,
    ST_NEXT
  } ecs_state_e;

endpackage : ecs_pkg

/* File: ecs_scanner.sv */
// Eight-channel BCD converter scanner with its write-back FIFO
`timescale 1ns/10ps

module ecs_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg < (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_core_clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      case ({push, pop})
        2'b10: count_reg <= count_reg + 1'b1;
        2'b01: count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end

endmodule : ecs_fifo

module ecs_scanner
  import ecs_pkg::*;
#(
  parameter int unsigned SCAN_LIMIT = SCAN_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Scan request and status
  input wire logic i_scan_start,
  output logic o_scan_busy,
  output logic o_scan_done,
  output logic o_scan_late,
  output logic [ADDR_W-1:0] o_last_channel_address,
  // Converter and multiplexer pins
  input wire logic [7:0] i_converter_input_port,
  input wire logic i_done_sense_line,
  output logic o_strobe_drive_line,
  output logic [CHAN_W-1:0] o_channel_select,
  // Memory write stream
  output logic o_mem_valid,
  input wire logic i_mem_ready,
  output ecs_mem_write_s o_mem_write
);

  ecs_state_e state_reg;
  logic [7:0] port_meta_reg;
  logic [7:0] port_sync_reg;
  logic eoc_meta_reg;
  logic eoc_sync_reg;
  logic eoc_prev_reg;
  logic eoc_pend_reg;
  logic eoc_rise;
  logic eoc_take;
  logic [1:0] cycles_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic [7:0] ptr_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [ADDR_W-1:0] top_addr_reg;
  logic [3:0] top_raw_reg;
  logic strobe_reg;
  logic done_reg;
  logic late_reg;
  logic [31:0] scan_cnt_reg;
  logic [ADDR_W-1:0] last_addr_reg;
  ecs_mem_write_s wr_word;
  logic wr_valid;
  logic wr_ready;
  logic digit_hit;
  logic [3:0] digit;
  logic [7:0] recoded;

  // Pins are asynchronous to the core clock; bits of the port may skew by a cycle,
  // the converter's interdigit blanking keeps a selected digit stable long enough.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      port_meta_reg <= 8'h00;
      port_sync_reg <= 8'h00;
      eoc_meta_reg <= 1'b0;
      eoc_sync_reg <= 1'b0;
      eoc_prev_reg <= 1'b0;
    end
    else
    begin
      port_meta_reg <= i_converter_input_port;
      port_sync_reg <= port_meta_reg;
      eoc_meta_reg <= i_done_sense_line;
      eoc_sync_reg <= eoc_meta_reg;
      eoc_prev_reg <= eoc_sync_reg;
    end
  end

  // Pulse is 1.25 us, over twelve core cycles, so the edge is never missed
  assign eoc_rise = eoc_sync_reg && !eoc_prev_reg;
  assign eoc_take = (state_reg == ST_SYNC || state_reg == ST_WAIT) && eoc_pend_reg;

  // Sticky event; a new edge in the acknowledge cycle stays pending
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      eoc_pend_reg <= 1'b0;
    end
    else if (eoc_rise)
    begin
      eoc_pend_reg <= 1'b1;
    end
    else if (eoc_take || state_reg == ST_IDLE)
    begin
      eoc_pend_reg <= 1'b0;
    end
  end

  assign digit = port_sync_reg[3:0] & BCD_MASK;
  assign digit_hit = (port_sync_reg & ptr_reg) != 8'h00;
  assign recoded = {~top_raw_reg[POL_BIT], 6'h00, ~top_raw_reg[HALF_BIT]};

  always_comb
  begin
    wr_valid = 1'b0;
    wr_word.addr = wr_addr_reg;
    wr_word.data = {4'h0, digit};
    if (state_reg == ST_COLLECT)
    begin
      wr_valid = digit_hit;
    end
    else if (state_reg == ST_FIX)
    begin
      wr_valid = 1'b1;
      wr_word.addr = top_addr_reg;
      if ((top_raw_reg & RANGE_MASK) == OVER_CODE)
      begin
        wr_word.data = OVER_MARK;
      end
      else
      begin
        wr_word.data = recoded;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= ST_IDLE;
      cycles_reg <= 2'h0;
      chan_reg <= '0;
      ptr_reg <= PTR_START;
      wr_addr_reg <= STORE_BASE;
      top_addr_reg <= STORE_BASE;
      top_raw_reg <= 4'h0;
      strobe_reg <= 1'b0;
      done_reg <= 1'b0;
      last_addr_reg <= STORE_BASE;
    end
    else
    begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (i_scan_start)
          begin
            state_reg <= ST_SYNC;
          end
        end
        ST_SYNC:
        begin
          // First pulse only aligns the scanner to the converter's cycle
          if (eoc_take)
          begin
            chan_reg <= '0;
            top_addr_reg <= STORE_BASE;
            wr_addr_reg <= STORE_BASE;
            cycles_reg <= CYCLES_FIRST_AFTER_SYNC;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (cycles_reg == 2'h1)
          begin
            strobe_reg <= 1'b1;
          end
          if (eoc_take)
          begin
            if (cycles_reg == 2'h1)
            begin
              strobe_reg <= 1'b0;
              ptr_reg <= PTR_START;
              state_reg <= ST_COLLECT;
            end
            else
            begin
              cycles_reg <= cycles_reg - 2'h1;
            end
          end
        end
        ST_COLLECT:
        begin
          if (digit_hit && wr_ready)
          begin
            if (ptr_reg == PTR_START)
            begin
              top_raw_reg <= digit;
            end
            wr_addr_reg <= wr_addr_reg + 16'h0001;
            ptr_reg <= {ptr_reg[6:0], 1'b0};
            if (ptr_reg == PTR_LAST)
            begin
              state_reg <= ST_FIX;
            end
          end
        end
        ST_FIX:
        begin
          if (wr_ready)
          begin
            last_addr_reg <= top_addr_reg;
            state_reg <= ST_NEXT;
          end
        end
        ST_NEXT:
        begin
          if (chan_reg == LAST_CHAN)
          begin
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
          else
          begin
            chan_reg <= chan_reg + 1'b1;
            top_addr_reg <= top_addr_reg + CHAN_STRIDE;
            cycles_reg <= CYCLES_LATER;
            state_reg <= ST_WAIT;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Scan duration watch: flags a scan that runs past the expected time
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      scan_cnt_reg <= 32'h0;
      late_reg <= 1'b0;
    end
    else if (state_reg == ST_IDLE)
    begin
      scan_cnt_reg <= 32'h0;
      if (i_scan_start)
      begin
        late_reg <= 1'b0;
      end
    end
    else
    begin
      if (scan_cnt_reg != 32'hffffffff)
      begin
        scan_cnt_reg <= scan_cnt_reg + 32'h1;
      end
      if (scan_cnt_reg >= SCAN_LIMIT)
      begin
        late_reg <= 1'b1;
      end
    end
  end

  ecs_fifo #(
    .WIDTH(WR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(wr_valid),
    .o_in_ready(wr_ready),
    .i_in_data(wr_word),
    .o_out_valid(o_mem_valid),
    .i_out_ready(i_mem_ready),
    .o_out_data(o_mem_write)
  );

  assign o_scan_busy = (state_reg != ST_IDLE);
  assign o_scan_done = done_reg;
  assign o_scan_late = late_reg;
  assign o_last_channel_address = last_addr_reg;
  assign o_strobe_drive_line = strobe_reg;
  assign o_channel_select = chan_reg;

endmodule : ecs_scanner

/* File: ecs_scanner_asserts.sv */
// Port-level checks for the scanner
`timescale 1ns/10ps
module ecs_scanner_asserts
  import ecs_pkg::*;
(
  // Watched ports
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_scan_start,
  input wire logic o_scan_busy,
  input wire logic o_scan_done,
  input wire logic [ADDR_W-1:0] o_last_channel_address,
  input wire logic o_strobe_drive_line,
  input wire logic [CHAN_W-1:0] o_channel_select,
  input wire logic o_mem_valid,
  input wire logic i_mem_ready,
  input wire ecs_mem_write_s o_mem_write
);
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  start_busy_a: assert property (
    !o_scan_busy && i_scan_start |=> o_scan_busy) else $error("start not taken");
  done_end_a: assert property (
    o_scan_done |-> !o_scan_busy && $past(o_scan_busy)) else $error("stray done");
  strobe_hold_a: assert property (
    $rose(o_strobe_drive_line) |-> o_strobe_drive_line[*8]) else $error("short strobe");
  chan_hold_a: assert property (
    o_strobe_drive_line && $past(o_strobe_drive_line) |-> $stable(o_channel_select))
    else $error("channel moved");
  addr_range_a: assert property (
    o_mem_valid |-> o_mem_write.addr inside {[16'h0010:16'h002f]}) else $error("bad address");
  data_form_a: assert property (
    o_mem_valid |-> o_mem_write.data[6:4] == 3'h0 || o_mem_write.data == 8'hf1)
    else $error("bad data");
  mem_hold_a: assert property (
    o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem_write))
    else $error("word dropped");
  last_addr_a: assert property (
    o_scan_done |-> o_last_channel_address == 16'h002c) else $error("bad last address");
endmodule : ecs_scanner_asserts

bind ecs_scanner ecs_scanner_asserts chk_u (
  .i_core_clk, .i_rst_n, .i_scan_start, .o_scan_busy, .o_scan_done, .o_last_channel_address,
  .o_strobe_drive_line, .o_channel_select, .o_mem_valid, .i_mem_ready, .o_mem_write
);

/* File: ecs_adc_model.sv */
// Behavioural multiplexed-BCD converter with its input multiplexer
`timescale 1ns/10ps
module ecs_adc_model (
  // Scanner side
  input wire logic [2:0] i_channel_select,
  input wire logic i_strobe_drive_line,
  output logic o_done_sense_line,
  output logic [7:0] o_converter_input_port
);
  // Raw reading per channel, top digit first
  logic [15:0] val [8];
  logic [15:0] shown = 16'hffff;
  logic [2:0] prev = 3'h0;
  logic up = 1'b0;
  int reps = 4;
  always @(posedge i_strobe_drive_line)
    up = 1'b1;
  initial
  begin
    o_done_sense_line = 1'b0;
    forever
    begin
      repeat (reps)
        for (int d = 0; d < 4; d++)
        begin
          o_converter_input_port = {4'h1 << d, shown[15 - 4 * d -: 4]};
          #2000;
          // Blanking gap shows garbage on the data lines
          o_converter_input_port = {4'h0, ~shown[15 - 4 * d -: 4]};
          #500;
        end
      // Polarity is the one decided in the previous cycle
      if (up)
        shown = {val[i_channel_select][15], val[prev][14], val[i_channel_select][13:0]};
      prev = i_channel_select;
      up = 1'b0;
      o_done_sense_line = 1'b1;
      #1250;
      o_done_sense_line = 1'b0;
    end
  end
endmodule : ecs_adc_model

/* File: ecs_scanner_tb.sv */
// Self-checking bench for the scanner
`timescale 1ns/10ps
module ecs_scanner_tb
  import ecs_pkg::*;
  ;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_scan_start = 1'b0;
  logic i_mem_ready = 1'b0;
  logic o_scan_busy, o_scan_done, o_scan_late, o_strobe_drive_line, o_mem_valid;
  logic i_done_sense_line;
  logic [7:0] i_converter_input_port;
  logic [ADDR_W-1:0] o_last_channel_address;
  logic [CHAN_W-1:0] o_channel_select;
  ecs_mem_write_s o_mem_write;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int eocs = 0;
  int ch_exp = 0;
  int rdy_pct = 75;
  int exp_q[$];

  always #50 i_core_clk = ~i_core_clk;

  // Limit sits between the fast and the slow converter scan times
  ecs_scanner #(.SCAN_LIMIT(20000)) dut_u (
    .i_core_clk, .i_rst_n, .i_scan_start, .o_scan_busy, .o_scan_done, .o_scan_late,
    .o_last_channel_address, .i_converter_input_port, .i_done_sense_line,
    .o_strobe_drive_line, .o_channel_select, .o_mem_valid, .i_mem_ready, .o_mem_write
  );
  ecs_adc_model adc_u (
    .i_channel_select(o_channel_select), .i_strobe_drive_line(o_strobe_drive_line),
    .o_done_sense_line(i_done_sense_line), .o_converter_input_port(i_converter_input_port)
  );

  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      bad_count++;
      final_report();
    end
    if (i_rst_n && o_mem_valid && i_mem_ready)
      check("word", o_mem_write, exp_q.size() ? exp_q.pop_front() : -1);
  end

  always @(negedge i_core_clk)
    i_mem_ready <= ($urandom % 100) < rdy_pct;

  always @(posedge i_done_sense_line)
    eocs++;

  always @(o_strobe_drive_line)
    if (i_rst_n && o_scan_busy)
    begin
      check("cycles", eocs, o_strobe_drive_line && ch_exp == 0 ? 2 : 1);
      eocs = 0;
      if (o_strobe_drive_line)
      begin
        check("channel", o_channel_select, ch_exp);
        ch_exp++;
      end
    end

  task automatic reset_run();
    i_rst_n = 1'b0;
    repeat (5) @(negedge i_core_clk);
    check("reset", {o_scan_busy, o_scan_done, o_strobe_drive_line, o_channel_select,
      o_mem_valid, o_last_channel_address}, 24'h10);
    exp_q.delete();
    i_rst_n = 1'b1;
    $display("reset checked");
  endtask : reset_run

  task automatic scan(logic exp_late);
    int t;
    logic [15:0] v;
    for (int c = 0; c < 8; c++)
    begin
      t = $urandom;
      v = {t[0], c[0], t[0] | t[1], t[1], 4'($urandom % 10), 4'($urandom % 10),
        4'($urandom % 10)};
      adc_u.val[c] = v;
      for (int k = 0; k < 4; k++)
        exp_q.push_back((16 + 4 * c + k) << 8 | v[15 - 4 * k -: 4]);
      exp_q.push_back((16 + 4 * c) << 8 |
        ((v[15:12] & 4'hb) == 4'h3 ? 8'hf1 : {~v[14], 6'h00, ~v[15]}));
    end
    @(negedge i_done_sense_line);
    repeat (20) @(negedge i_core_clk);
    eocs = 0;
    ch_exp = 0;
    i_scan_start = 1'b1;
    @(negedge i_core_clk);
    i_scan_start = 1'b0;
    // A second request mid-scan must be ignored
    repeat (3000) @(negedge i_core_clk);
    i_scan_start = 1'b1;
    @(negedge i_core_clk);
    i_scan_start = 1'b0;
    while (o_scan_done !== 1'b1)
      @(negedge i_core_clk);
    while (o_mem_valid !== 1'b0)
      @(negedge i_core_clk);
    check("busy", o_scan_busy, 0);
    check("left", exp_q.size(), 0);
    check("last", o_last_channel_address, 16'h002c);
    check("late", o_scan_late, exp_late);
    $display("scan finished");
  endtask : scan

  initial
  begin
    void'($urandom(32'ha6b0ad6d));
    reset_run();
    scan(1'b0);
    fork
      scan(1'b0);
      begin
        repeat (1500) @(negedge i_core_clk);
        rdy_pct = 0;
        repeat (1500) @(negedge i_core_clk);
        rdy_pct = 75;
      end
    join
    i_scan_start = 1'b1;
    repeat (300) @(negedge i_core_clk);
    i_scan_start = 1'b0;
    reset_run();
    adc_u.reps = 20;
    scan(1'b1);
    final_report();
  end
endmodule : ecs_scanner_tb
